// ==== pkg/hidsel_pkg.sv ====
// hidsel_pkg: offsets, defaults and modes for the hub id select registers
// assumes byte-wide configuration access on an 8-bit offset
package hidsel_pkg;
  localparam logic [7:0] HIDSEL_OFS_VID_HI  = 8'h02;
  localparam logic [7:0] HIDSEL_OFS_PID_LO  = 8'h03;
  localparam logic [7:0] HIDSEL_OFS_PID_HI  = 8'h04;
  // built-in fallback bytes; values arbitrary, not a real maker code
  localparam logic [7:0] HIDSEL_DEF_VID_HI  = 8'h12;
  localparam logic [7:0] HIDSEL_DEF_PID_LO  = 8'h34;
  localparam logic [7:0] HIDSEL_DEF_PID_HI  = 8'h56;
  // usb 2.0 descriptor flips bit 1 of the product id low byte
  localparam logic [7:0] HIDSEL_USB2_FLIP   = 8'h02;
  localparam int         HIDSEL_NUM_BYTES   = 3;
  typedef enum logic {
    HIDSEL_MODE_PIN,
    HIDSEL_MODE_CFG
  } hidsel_mode_t;
endpackage : hidsel_pkg

// ==== logic/hidsel_pick.sv ====
// hidsel_pick: three-way source choice for one id byte
// assumes the caller decides whether the external pair counts as written
`timescale 1ns/1ps
module hidsel_pick (
  // selection inputs
  input  wire logic       ext_ok_i,
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] otp_i,
  input  wire logic [7:0] def_i,
  // chosen byte
  output logic      [7:0] sel_o
);
  // external wins, then otp, then built-in default
  always_comb begin
    if (ext_ok_i) begin
      sel_o = ext_i;
    end else if (otp_i != 8'h00) begin
      sel_o = otp_i;
    end else begin
      sel_o = def_i;
    end
  end
endmodule : hidsel_pick

// ==== logic/hidsel_regs.sv ====
// hidsel_regs: id byte registers and the id values reported to usb
// assumes a synchronous byte write port driven by eeprom loader or smbus
`timescale 1ns/1ps
module hidsel_regs
  import hidsel_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // configuration mode
  input  wire logic       cfg_mode_i,
  // byte write and read port
  input  wire logic       wr_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // external low vendor byte, kept elsewhere
  input  wire logic [7:0] vid_lo_i,
  // otp contents
  input  wire logic [7:0] otp_vid_hi_i,
  input  wire logic [7:0] otp_pid_lo_i,
  input  wire logic [7:0] otp_pid_hi_i,
  // ids in use
  output logic      [7:0] vid_hi_o,
  output logic      [7:0] pid_lo_ss_o,
  output logic      [7:0] pid_lo_usb2_o,
  output logic      [7:0] pid_hi_o
);
  logic [7:0] vendor_id_high_byte;
  logic [7:0] product_id_low_byte;
  logic [7:0] product_id_high_byte;
  logic [7:0] next_vendor_id_high_byte;
  logic [7:0] next_product_id_low_byte;
  logic [7:0] next_product_id_high_byte;
  logic [7:0] next_rdata;
  logic [7:0] next_vid_hi;
  logic [7:0] next_pid_lo;
  logic [7:0] next_pid_hi;
  logic       ext_ok;
  hidsel_mode_t mode;

  assign mode = cfg_mode_i ? HIDSEL_MODE_CFG : HIDSEL_MODE_PIN;

  // byte writes; ignored outside configuration mode
  always_comb begin
    next_vendor_id_high_byte  = vendor_id_high_byte;
    next_product_id_low_byte  = product_id_low_byte;
    next_product_id_high_byte = product_id_high_byte;
    if (wr_i && mode == HIDSEL_MODE_CFG) begin
      unique case (addr_i)
        HIDSEL_OFS_VID_HI: next_vendor_id_high_byte  = wdata_i;
        HIDSEL_OFS_PID_LO: next_product_id_low_byte  = wdata_i;
        HIDSEL_OFS_PID_HI: next_product_id_high_byte = wdata_i;
        default: ;
      endcase
    end
  end

  // readback of stored bytes; unmapped offsets read zero
  always_comb begin
    unique case (addr_i)
      HIDSEL_OFS_VID_HI: next_rdata = vendor_id_high_byte;
      HIDSEL_OFS_PID_LO: next_rdata = product_id_low_byte;
      HIDSEL_OFS_PID_HI: next_rdata = product_id_high_byte;
      default:           next_rdata = 8'h00;
    endcase
  end

  // external pair counts only if neither whole id is zero
  assign ext_ok = ({vendor_id_high_byte, vid_lo_i} != 16'h0000) &&
                  ({product_id_high_byte, product_id_low_byte}
                   != 16'h0000);

  hidsel_pick u_pick_vid_hi (
    .ext_ok_i (ext_ok),
    .ext_i    (vendor_id_high_byte),
    .otp_i    (otp_vid_hi_i),
    .def_i    (HIDSEL_DEF_VID_HI),
    .sel_o    (next_vid_hi)
  );
  hidsel_pick u_pick_pid_lo (
    .ext_ok_i (ext_ok),
    .ext_i    (product_id_low_byte),
    .otp_i    (otp_pid_lo_i),
    .def_i    (HIDSEL_DEF_PID_LO),
    .sel_o    (next_pid_lo)
  );
  hidsel_pick u_pick_pid_hi (
    .ext_ok_i (ext_ok),
    .ext_i    (product_id_high_byte),
    .otp_i    (otp_pid_hi_i),
    .def_i    (HIDSEL_DEF_PID_HI),
    .sel_o    (next_pid_hi)
  );

  // registers; outputs registered so descriptors see stable bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vendor_id_high_byte  <= HIDSEL_DEF_VID_HI;
      product_id_low_byte  <= HIDSEL_DEF_PID_LO;
      product_id_high_byte <= HIDSEL_DEF_PID_HI;
      rdata_o              <= 8'h00;
      vid_hi_o             <= HIDSEL_DEF_VID_HI;
      pid_lo_ss_o          <= HIDSEL_DEF_PID_LO;
      pid_lo_usb2_o        <= HIDSEL_DEF_PID_LO ^ HIDSEL_USB2_FLIP;
      pid_hi_o             <= HIDSEL_DEF_PID_HI;
    end else begin
      vendor_id_high_byte  <= next_vendor_id_high_byte;
      product_id_low_byte  <= next_product_id_low_byte;
      product_id_high_byte <= next_product_id_high_byte;
      rdata_o              <= next_rdata;
      vid_hi_o             <= next_vid_hi;
      pid_lo_ss_o          <= next_pid_lo;
      pid_lo_usb2_o        <= next_pid_lo ^ HIDSEL_USB2_FLIP;
      pid_hi_o             <= next_pid_hi;
    end
  end
endmodule : hidsel_regs

// ==== tb/hidsel_chk_properties.sv ====
// hidsel_chk: port timing checks for the id select registers
// assumes bind onto hidsel_regs with ports matched by name
`timescale 1ns/1ps
module hidsel_chk
  import hidsel_pkg::*;
(
  // watched ports; ports not listed here are left unwatched
  input wire logic       clk_i, rst_i, cfg_mode_i, wr_i,
  input wire logic [7:0] addr_i, wdata_i, rdata_o, pid_lo_ss_o, pid_lo_usb2_o,
  input wire logic [7:0] vid_hi_o, pid_hi_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_usb2_flip: assert property (
    pid_lo_usb2_o == (pid_lo_ss_o ^ HIDSEL_USB2_FLIP)) else $error("usb2 low");
  a_pid_hi_wr: assert property (
    wr_i && cfg_mode_i && addr_i == HIDSEL_OFS_PID_HI ##1 !wr_i &&
    addr_i == HIDSEL_OFS_PID_HI |=> rdata_o == $past(wdata_i, 2))
    else $error("pid high write lost");
  a_refuse_wr: assert property (
    wr_i && !cfg_mode_i && addr_i == HIDSEL_OFS_VID_HI ##1 !wr_i &&
    addr_i == HIDSEL_OFS_VID_HI |=> $stable(rdata_o))
    else $error("write taken outside config mode");
  a_vid_hi_wr: assert property (
    wr_i && cfg_mode_i && addr_i == HIDSEL_OFS_VID_HI ##1 !wr_i &&
    addr_i == HIDSEL_OFS_VID_HI |=> rdata_o == $past(wdata_i, 2))
    else $error("vid high write lost");
  a_unmapped_zero: assert property (
    addr_i != HIDSEL_OFS_VID_HI && addr_i != HIDSEL_OFS_PID_LO &&
    addr_i != HIDSEL_OFS_PID_HI |=> rdata_o == 8'h00)
    else $error("unmapped offset not zero");
  a_reset_ids: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> vid_hi_o == HIDSEL_DEF_VID_HI &&
    pid_hi_o == HIDSEL_DEF_PID_HI && rdata_o == 8'h00)
    else $error("reset values wrong");
endmodule : hidsel_chk
bind hidsel_regs hidsel_chk u_hidsel_chk (.*);

// ==== tb/hidsel_host.sv ====
// hidsel_host: eeprom loader or smbus host writing id bytes
// assumes the bench calls put and peek; drives at falling edges
`timescale 1ns/1ps
module hidsel_host (
  input  wire logic       clk_i,
  output logic            wr_o = 1'b0,
  output logic      [7:0] addr_o = 8'h00,
  output logic      [7:0] wdata_o = 8'h00
);
  // strobe left high so writes may run back to back
  task automatic put(input logic [7:0] a, d);
    @(negedge clk_i); wr_o = 1'b1; addr_o = a; wdata_o = d;
  endtask : put
  // data released on reads, so it flips rather than holds
  task automatic peek(input logic [7:0] a);
    @(negedge clk_i); wr_o = 1'b0; addr_o = a; wdata_o = ~wdata_o;
    repeat (2) @(negedge clk_i);
  endtask : peek
endmodule : hidsel_host

// ==== tb/tb.sv ====
// tb: self-checking bench for hidsel_regs with a host model
// assumes 50 MHz clock; inputs change at falling edges
`timescale 1ns/1ps
`define CHK(a, b) n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end
module tb;
  import hidsel_pkg::*;
  logic       clk_i = 0, rst_i = 1, cfg = 1, wr;
  logic [7:0] addr, wdata, rdata, vh, pl, pu, ph;
  int         n_errors = 0, n_compared = 0;
  always #10 clk_i = ~clk_i;
  hidsel_host u_hidsel_host (.clk_i, .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
  // otp: vid high and pid high set, pid low blank to force default
  hidsel_regs u_hidsel_regs (.clk_i, .rst_i, .cfg_mode_i(cfg), .wr_i(wr),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .vid_lo_i(8'h00),
    .otp_vid_hi_i(8'ha1), .otp_pid_lo_i(8'h00), .otp_pid_hi_i(8'hc3),
    .vid_hi_o(vh), .pid_lo_ss_o(pl), .pid_lo_usb2_o(pu), .pid_hi_o(ph));
  task automatic rd(input logic [7:0] a, x);
    u_hidsel_host.peek(a);
    `CHK(rdata, x)
  endtask : rd
  task automatic ids(input logic [7:0] v, l, h);
    `CHK(vh, v) `CHK(pl, l) `CHK(ph, h)
    `CHK(pu, l ^ HIDSEL_USB2_FLIP)
  endtask : ids
  task print_verdict;
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // whole run is under 60 cycles
  initial begin
    #100000; n_errors++; print_verdict;
  end
  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 0;
    rd(HIDSEL_OFS_VID_HI, HIDSEL_DEF_VID_HI);
    ids(HIDSEL_DEF_VID_HI, HIDSEL_DEF_PID_LO, HIDSEL_DEF_PID_HI);
    u_hidsel_host.put(HIDSEL_OFS_VID_HI, 8'hab);
    u_hidsel_host.put(HIDSEL_OFS_PID_LO, 8'h00);
    u_hidsel_host.put(HIDSEL_OFS_PID_HI, 8'h9c);
    rd(HIDSEL_OFS_PID_HI, 8'h9c);
    rd(HIDSEL_OFS_VID_HI, 8'hab);
    ids(8'hab, 8'h00, 8'h9c);
    cfg = 0;
    u_hidsel_host.put(HIDSEL_OFS_VID_HI, 8'h55);
    rd(HIDSEL_OFS_VID_HI, 8'hab);
    cfg = 1;
    rd(8'h05, 8'h00);
    u_hidsel_host.put(HIDSEL_OFS_VID_HI, 8'h00);
    u_hidsel_host.put(HIDSEL_OFS_PID_HI, 8'h00);
    rd(HIDSEL_OFS_VID_HI, 8'h00);
    ids(8'ha1, HIDSEL_DEF_PID_LO, 8'hc3);
    // mid-run reset must reload the built-in bytes
    rst_i = 1;
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    rd(HIDSEL_OFS_PID_HI, HIDSEL_DEF_PID_HI);
    ids(HIDSEL_DEF_VID_HI, HIDSEL_DEF_PID_LO, HIDSEL_DEF_PID_HI);
    print_verdict;
  end
endmodule : tb
